// ===== common/dcto_params.svh
// Constants for the dual-channel torque-off monitor: timing and encodings.
// Assumes a 125 MHz system clock; counts are derived from times in us.
`ifndef DCTO_PARAMS_SVH
`define DCTO_PARAMS_SVH

`define DCTO_CLK_MHZ          125
// Least input break taken as a demand, in microseconds
`define DCTO_FILT_US          1000
`define DCTO_FILT_CYC         (`DCTO_FILT_US * `DCTO_CLK_MHZ)
// Mismatch must last longer than this, in microseconds
`define DCTO_MISM_US          200000
`define DCTO_MISM_CYC         (`DCTO_MISM_US * `DCTO_CLK_MHZ)
// Longest response after a valid demand, in microseconds
`define DCTO_RESP_MAX_US      5000
// Fault indication must come before this, in microseconds
`define DCTO_FAULT_IND_US     500000
// Warning indication must come before this, in microseconds
`define DCTO_WARN_IND_US      1000000
// Fault reaction completes within this after detection, in microseconds
`define DCTO_REACT_US         10000
// Indication select codes, per running/stopped state
`define DCTO_IND_NONE         2'h0
`define DCTO_IND_WARN         2'h1
`define DCTO_IND_FAULT        2'h2
`define DCTO_CNT_W            25

`endif

// ===== common/dcto_pkg.sv
// Types for the dual-channel torque-off monitor.
// Used by the monitor top and its input filter.
package dcto_pkg;

  typedef enum logic [1:0] {
    DCTO_RUN_OK,
    DCTO_RUN_OFF,
    DCTO_RUN_LOCK
  } dcto_state_type;

endpackage : dcto_pkg

// ===== hw/dcto_filter.sv
// Glitch filter for one torque-off input channel.
// Input is synchronous to clk_i; output follows only a level held long enough.
`timescale 1ns/1ps
`include "dcto_params.svh"

module dcto_filter
  import dcto_pkg::*;
#(
  parameter int unsigned FILT_CYC = `DCTO_FILT_CYC
)
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic raw_i,
  output logic      level_o
);

  logic [`DCTO_CNT_W-1:0] cnt_q;
  logic                   level_q;

  // ----------------------------------------------------------------------
  // Hold filter
  // ----------------------------------------------------------------------
  // Counter runs while raw differs from the accepted level; pulses that
  // end early restart it, so short breaks never reach the output.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q   <= '0;
      level_q <= 1'b0; // Safe: treat as de-energized until proven
    end
    else if (raw_i == level_q)
    begin
      cnt_q <= '0;
    end
    else if (cnt_q >= `DCTO_CNT_W'(FILT_CYC - 1))
    begin
      cnt_q   <= '0;
      level_q <= raw_i;
    end
    else
    begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign level_o = level_q;

endmodule : dcto_filter

// ===== hw/dcto_monitor.sv
// Dual-channel torque-off monitor: gate enable, restart lock, indication
// and latched channel mismatch fault.
// Inputs are synchronous to clk_i; input high means energized (run allowed).
//
// Contract
// - Both inputs off: remove gate drive
// - Raise indication chosen per running/stopped
// - Inputs open: refuse restart, stage off
// - Fault reset required before restart
// - Torque-off overrides every other enable
// - Channel disagreement trips mismatch fault
// - Single-channel use gives same fault
// - Mismatch counts only after 200 ms
// - Fault reaction within 10 ms
// - Breaks of 1 ms recognised, shorter filtered
// - Gate drive removed within 5 ms
// - Fault indication under 500 ms
// - Warning indication under 1000 ms
// - Start during torque-off: reject, warn
`timescale 1ns/1ps
`include "dcto_params.svh"

module dcto_monitor
  import dcto_pkg::*;
#(
  parameter int unsigned FILT_CYC = `DCTO_FILT_CYC,
  parameter int unsigned MISM_CYC = `DCTO_MISM_CYC
)
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [1:0] torque_off_input_channel_i,
  input  wire logic       start_req_i,
  input  wire logic       stop_req_i,
  input  wire logic       fault_reset_i,
  input  wire logic [1:0] ind_sel_run_i,
  input  wire logic [1:0] ind_sel_stop_i,
  output logic            gate_enable_o,
  output logic            running_o,
  output logic            torque_off_active_o,
  output logic            torque_off_warning_o,
  output logic            torque_off_fault_o,
  output logic            start_rejected_warning_o,
  output logic            dual_channel_mismatch_fault_o
);

  logic [1:0]             chan_lvl;
  logic                   both_off;
  logic                   mism;
  logic [`DCTO_CNT_W-1:0] mism_cnt_q;
  logic                   mism_fault_q;
  logic                   fault_pend_q;
  dcto_state_type         state_q;
  logic                   sto_q;
  logic                   warn_q;
  logic                   fault_q;
  logic                   rej_q;

  // Decode the selected indication for the state at activation
  function automatic logic [1:0] sel_ind(input logic run,
                                         input logic [1:0] sr,
                                         input logic [1:0] ss);
    sel_ind = run ? sr : ss;
  endfunction : sel_ind

  // ----------------------------------------------------------------------
  // Input filtering
  // ----------------------------------------------------------------------
  // One filter per channel so each channel is judged independently
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_chan
      dcto_filter #(
        .FILT_CYC (FILT_CYC)
      ) u_filt (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .raw_i   (torque_off_input_channel_i[g]),
        .level_o (chan_lvl[g])
      );
    end
  endgenerate

  assign both_off = ~chan_lvl[0] & ~chan_lvl[1];
  assign mism     = chan_lvl[0] ^ chan_lvl[1];

  // ----------------------------------------------------------------------
  // Mismatch detection
  // ----------------------------------------------------------------------
  // Count cycles of disagreement; trip once it lasts longer than the limit
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      mism_cnt_q <= '0;
    else if (!mism)
      mism_cnt_q <= '0;
    else if (mism_cnt_q <= `DCTO_CNT_W'(MISM_CYC))
      mism_cnt_q <= mism_cnt_q + 1'b1;
  end

  // Latched fault; a new trip in the reset cycle wins over the clear
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      mism_fault_q <= 1'b0;
    else if (mism && mism_cnt_q == `DCTO_CNT_W'(MISM_CYC))
      mism_fault_q <= 1'b1;
    else if (fault_reset_i && !mism)
      mism_fault_q <= 1'b0;
  end

  // Marks the cycle after detection, when the reaction is applied
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      fault_pend_q <= 1'b0;
    else
      fault_pend_q <= mism && mism_cnt_q == `DCTO_CNT_W'(MISM_CYC);
  end

  // ----------------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------------
  // LOCK waits for inputs closed and a fault reset; nothing bypasses it.
  // The reset that clears a latched mismatch also releases the lock, so
  // one reset pulse is enough after the channels agree again.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_q <= DCTO_RUN_LOCK;
    else if (both_off || mism || (mism_fault_q && !fault_reset_i))
      state_q <= DCTO_RUN_LOCK;
    else
    begin
      unique case (state_q)
        DCTO_RUN_LOCK:
          if (fault_reset_i)
            state_q <= DCTO_RUN_OFF;
        DCTO_RUN_OFF:
          if (start_req_i && !stop_req_i)
            state_q <= DCTO_RUN_OK;
        DCTO_RUN_OK:
          if (stop_req_i)
            state_q <= DCTO_RUN_OFF;
      endcase
    end
  end

  // Gate drive only in RUN_OK with both channels energized
  assign gate_enable_o = (state_q == DCTO_RUN_OK) & chan_lvl[0]
                         & chan_lvl[1] & ~mism_fault_q;
  assign running_o     = state_q == DCTO_RUN_OK;

  // ----------------------------------------------------------------------
  // Indication
  // ----------------------------------------------------------------------
  // Indication type is captured at activation from the running state
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sto_q     <= 1'b0;
      warn_q    <= 1'b0;
      fault_q   <= 1'b0;
    end
    else
    begin
      sto_q <= both_off;
      if (both_off && !sto_q)
      begin
        warn_q    <= sel_ind(state_q == DCTO_RUN_OK, ind_sel_run_i,
                             ind_sel_stop_i) == `DCTO_IND_WARN;
        fault_q   <= sel_ind(state_q == DCTO_RUN_OK, ind_sel_run_i,
                             ind_sel_stop_i) == `DCTO_IND_FAULT;
      end
      else if (!both_off)
      begin
        warn_q <= 1'b0;
        if (fault_reset_i)
          fault_q <= 1'b0; // Fault indication stays until reset
      end
    end
  end

  // Start refused while torque-off is active; warn instead
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rej_q <= 1'b0;
    else if (both_off && start_req_i)
      rej_q <= 1'b1;
    else if (!both_off)
      rej_q <= 1'b0;
  end

  assign torque_off_active_o           = sto_q;
  assign torque_off_warning_o          = warn_q;
  assign torque_off_fault_o            = fault_q;
  assign start_rejected_warning_o      = rej_q;
  assign dual_channel_mismatch_fault_o = mism_fault_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_gate_off_both;
    @(posedge clk_i) disable iff (!rst_n_i)
      both_off |-> !gate_enable_o;
  endproperty
  a_gate_off_both: assert property (p_gate_off_both)
    else $error("gate enabled while both channels off");

  property p_no_restart;
    @(posedge clk_i) disable iff (!rst_n_i)
      both_off |=> state_q == DCTO_RUN_LOCK;
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("run state left lock while inputs open");

  property p_reset_needed;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_q == DCTO_RUN_LOCK && !fault_reset_i) |=>
        state_q == DCTO_RUN_LOCK;
  endproperty
  a_reset_needed: assert property (p_reset_needed)
    else $error("lock left without fault reset");

  property p_priority;
    @(posedge clk_i) disable iff (!rst_n_i)
      gate_enable_o |-> chan_lvl == 2'b11 && !mism_fault_q;
  endproperty
  a_priority: assert property (p_priority)
    else $error("gate enabled against torque-off");

  property p_trip;
    @(posedge clk_i) disable iff (!rst_n_i)
      (mism && mism_cnt_q == `DCTO_CNT_W'(MISM_CYC)) |=>
        mism_fault_q ##1 !gate_enable_o;
  endproperty
  a_trip: assert property (p_trip)
    else $error("mismatch did not trip and stop gate");

  property p_no_early;
    @(posedge clk_i) disable iff (!rst_n_i)
      $rose(mism_fault_q) |-> $past(mism_cnt_q) == `DCTO_CNT_W'(MISM_CYC);
  endproperty
  a_no_early: assert property (p_no_early)
    else $error("mismatch fault before limit");

  property p_latched;
    @(posedge clk_i) disable iff (!rst_n_i)
      (mism_fault_q && !fault_reset_i) |=> mism_fault_q;
  endproperty
  a_latched: assert property (p_latched)
    else $error("mismatch fault cleared without reset");

  property p_reject;
    @(posedge clk_i) disable iff (!rst_n_i)
      (both_off && start_req_i) |=> start_rejected_warning_o && !running_o;
  endproperty
  a_reject: assert property (p_reject)
    else $error("start during torque-off not rejected");

  property p_filter_response;
    @(posedge clk_i) disable iff (!rst_n_i)
      $fell(chan_lvl[0]) |-> !gate_enable_o;
  endproperty
  a_filter_response: assert property (p_filter_response)
    else $error("gate still on after channel break");

  c_trip: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(mism_fault_q));
  c_run: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(gate_enable_o));
  c_sto_run: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(both_off) && running_o);
  c_reject: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(start_rejected_warning_o));

endmodule : dcto_monitor

// ===== verification/dcto_relay_model.sv
// Model of the activation switch or safety relay contacts, two channels.
// Assumes the bench commands each contact at the falling clock edge.
`timescale 1ns/1ps

module dcto_relay_model
(
  input  wire logic [1:0] open_i,
  output logic      [1:0] chan_o
);
  // An open contact de-energizes its channel; the bench decides whether
  // the drive was stopped first, so coasting cases stay reachable
  assign chan_o = ~open_i;
endmodule : dcto_relay_model

// ===== verification/tb.sv
// Self-checking bench for the torque-off monitor, short filter counts.
// Assumes dcto_params.svh on the include path and dcto_pkg compiled first.
`timescale 1ns/1ps
`include "dcto_params.svh"

module tb;
  import dcto_pkg::*;
  localparam int FILT = 4;
  localparam int MISM = 20;
  logic       clk;
  logic       rst_n;
  logic       start_req;
  logic       stop_req;
  logic       fault_reset;
  logic [1:0] open_q;
  logic [1:0] chan;
  logic [1:0] sel_run;
  logic [1:0] sel_stop;
  logic [1:0] sel;
  logic       gate;
  logic       running;
  logic       active;
  logic       warn;
  logic       fault;
  logic       srw;
  logic       mism;
  logic       run_exp;
  int         errors;
  int         total_checks;
  int         cycles;

  dcto_relay_model dcto_relay_model_inst (.open_i(open_q), .chan_o(chan));

  dcto_monitor #(.FILT_CYC(FILT), .MISM_CYC(MISM)) dcto_monitor_inst (
    .clk_i(clk), .rst_n_i(rst_n), .torque_off_input_channel_i(chan),
    .start_req_i(start_req), .stop_req_i(stop_req),
    .fault_reset_i(fault_reset), .ind_sel_run_i(sel_run),
    .ind_sel_stop_i(sel_stop), .gate_enable_o(gate), .running_o(running),
    .torque_off_active_o(active), .torque_off_warning_o(warn),
    .torque_off_fault_o(fault), .start_rejected_warning_o(srw),
    .dual_channel_mismatch_fault_o(mism));

  // 125 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // -----------------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // Expected indication: raised only for the matching select code
  function automatic logic want_ind(input logic [1:0] code,
                                    input logic [1:0] kind);
    return code == kind;
  endfunction : want_ind

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask : pulse

  task automatic check(input logic seen, input logic exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: saw %b, want %b", $time, seen, exp);
    end
  endtask : check

  task automatic results;
    $display("errors %0d, checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  // Close both contacts, clear faults, start again
  task automatic restart;
    open_q = 2'b00;
    cyc(FILT + 2);
    pulse(fault_reset);
    pulse(start_req);
    cyc(1);
    check(gate, 1'b1);
    check(running, 1'b1);
    check(warn, 1'b0);
    check(fault, 1'b0);
    check(srw, 1'b0);
  endtask : restart

  // Hang guard: far above the expected few hundred cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      results();
    end
  end

  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial
  begin
    errors = 0; total_checks = 0; cycles = 0;
    rst_n = 1'b0; start_req = 1'b0; stop_req = 1'b0; fault_reset = 1'b0;
    open_q = 2'b11; sel_run = 2'h0; sel_stop = 2'h0;
    void'($urandom(32'h690cf36e));
    cyc(2);
    rst_n = 1'b1;
    // Start without fault reset after closing is refused
    open_q = 2'b00;
    cyc(FILT + 2);
    pulse(start_req);
    cyc(1);
    check(gate, 1'b0);
    check(running, 1'b0);
    restart();
    // Torque-off in running and stopped states, random selections;
    // code 3 is drawn too and must raise nothing
    for (int k = 0; k < 6; k++)
    begin
      run_exp = (k % 2 == 0);
      if (!run_exp)
      begin
        pulse(stop_req);
        cyc(1);
      end
      sel = 2'($urandom % 4);
      sel_run = run_exp ? sel : 2'($urandom % 4);
      sel_stop = run_exp ? 2'($urandom % 4) : sel;
      // Short break on both channels is filtered out
      open_q = 2'b11;
      cyc(1 + $urandom % (FILT - 1));
      open_q = 2'b00;
      cyc(FILT + 2);
      check(gate, run_exp);
      check(running, run_exp);
      open_q = 2'b11;
      cyc(FILT + 2);
      check(gate, 1'b0);
      check(running, 1'b0);
      check(active, 1'b1);
      check(warn, want_ind(sel, `DCTO_IND_WARN));
      check(fault, want_ind(sel, `DCTO_IND_FAULT));
      start_req = 1'b1;
      cyc(2);
      check(gate, 1'b0);
      check(srw, 1'b1);
      check(running, 1'b0);
      start_req = 1'b0;
      restart();
    end
    // One channel only: mismatch fault after the detection time
    open_q = ($urandom % 2) ? 2'b01 : 2'b10;
    cyc(FILT + 2);
    check(gate, 1'b0);
    cyc(MISM - 4);
    check(mism, 1'b0);
    cyc(8);
    check(mism, 1'b1);
    pulse(fault_reset);
    cyc(1);
    check(mism, 1'b1);
    open_q = 2'b00;
    cyc(FILT + 2);
    check(mism, 1'b1);
    check(gate, 1'b0);
    restart();
    check(mism, 1'b0);
    results();
  end
endmodule : tb
